// *** common/dac_cfg.svh ***
// command codes, field positions, reset values and timing counts
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH

`define FRAME_BITS      5'h18
`define CMD_HI          23
`define CMD_LO          20
`define ADDR_HI         19
`define ADDR_LO         16
`define DATA_HI         15
`define DATA_LO         0
`define CMD_WRITE_UPD   4'h3
`define CMD_SOFT_RESET  4'h6
`define CMD_REF_GAIN    4'h7
`define SOFT_RESET_ADDR 4'h0
`define SOFT_RESET_KEY  16'h1234
`define GAIN_BIT        2
`define REF_BIT         0
`define ZERO_CODE       16'h0000
`define MID_CODE        16'h8000
`define GAIN_RST        1'h0
`define REF_OFF_RST     1'h0
`define PIN_SYNC_RST    3'h1
`define INIT_CYCLES     2'h3

`endif

// *** common/dac_pkg.sv ***
// types shared by the serial receiver and the control block
package dac_pkg;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_SHIFT = 2'b01
    } rx_state_t;

    typedef logic [23:0] frame_word_t;

endpackage

// *** common/frame_if.sv ***
// carrier for a received command frame
`timescale 1ns/10ps
interface frame_if;
    dac_pkg::frame_word_t word;
    logic                 valid;

    modport tx (output word, output valid);
    modport rx (input word, input valid);
endinterface

// *** design/serial_frame_rx.sv ***
// serial receiver: samples the pins and delivers 24-bit frames
`timescale 1ns/10ps
`include "dac_cfg.svh"
module serial_frame_rx (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // serial pins
    input  wire logic sclk,
    input  wire logic sdin,
    input  wire logic sync_n,
    // received frame
    frame_if.tx       frm
);
    logic [2:0]           s1_ff;
    logic [2:0]           s2_ff;
    logic [2:0]           s3_ff;
    logic [4:0]           cnt_ff;
    logic [4:0]           nxt_cnt;
    logic [23:0]          shift_ff;
    logic [23:0]          nxt_shift;
    dac_pkg::frame_word_t word_ff;
    dac_pkg::frame_word_t nxt_word;
    logic                 valid_ff;
    logic                 nxt_valid;
    dac_pkg::rx_state_t   state_ff;
    dac_pkg::rx_state_t   nxt_state;
    logic                 sclk_fall;
    logic                 sync_rise;

    // bit 0 sclk, bit 1 sdin, bit 2 sync_n
    assign sclk_fall = s3_ff[0] & ~s2_ff[0];
    assign sync_rise = s2_ff[2] & ~s3_ff[2];

    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_shift = shift_ff;
        nxt_word  = word_ff;
        nxt_valid = 1'b0;
        nxt_state = state_ff;
        case (state_ff)
            dac_pkg::RX_IDLE: begin
                nxt_cnt = 5'h00;
                if (!s2_ff[2]) begin
                    nxt_state = dac_pkg::RX_SHIFT;
                end
            end
            dac_pkg::RX_SHIFT: begin
                if (sync_rise) begin
                    nxt_state = dac_pkg::RX_IDLE;
                    if (cnt_ff == `FRAME_BITS) begin
                        nxt_word  = shift_ff;
                        nxt_valid = 1'b1;
                    end
                end else if (sclk_fall && cnt_ff != 5'h1F) begin
                    nxt_shift = {shift_ff[22:0], s2_ff[1]};
                    nxt_cnt   = cnt_ff + 5'h01;
                end
            end
            default: nxt_state = dac_pkg::RX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s1_ff    <= 3'h7;
            s2_ff    <= 3'h7;
            s3_ff    <= 3'h7;
            cnt_ff   <= 5'h00;
            shift_ff <= 24'h000000;
            word_ff  <= 24'h000000;
            valid_ff <= 1'b0;
            state_ff <= dac_pkg::RX_IDLE;
        end else begin
            s1_ff    <= {sync_n, sdin, sclk};
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            cnt_ff   <= nxt_cnt;
            shift_ff <= nxt_shift;
            word_ff  <= nxt_word;
            valid_ff <= nxt_valid;
            state_ff <= nxt_state;
        end
    end

    assign frm.word  = word_ff;
    assign frm.valid = valid_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_full_frame_end;
        state_ff == dac_pkg::RX_SHIFT && sync_rise && cnt_ff == `FRAME_BITS;
    endsequence

    property p_frame_taken;
        s_full_frame_end |=> valid_ff && word_ff == $past(shift_ff);
    endproperty
    a_frame_taken: assert property (p_frame_taken)
        else $error("full frame not delivered at frame sync rise");

    property p_short_frame_dropped;
        sync_rise && cnt_ff != `FRAME_BITS |=> !valid_ff;
    endproperty
    a_short_frame_dropped: assert property (p_short_frame_dropped)
        else $error("frame of wrong length was delivered");
endmodule

// *** design/dac_reset_ref_gain.sv ***
// converter reset, power-up level and reference/gain setup control
// How it works
// - select input low: all channels start at zero-scale after power-on.
// - select input high: all channels start at midscale after power-on.
// - outputs hold their power-up level until a valid write arrives.
// - variant without select input always starts at zero-scale.
// - soft reset command restores power-on codes and state.
// - soft reset needs address zero and the fixed data key.
// - setup bit two selects gain: zero gives one, one gives two.
// - setup bit zero: zero keeps reference on, one turns it off.
// - setup has its own command; bits 19 to 3 ignored, bit one zero.
// - variant without gain pin takes gain from setup gain bit.
// - a frame is accepted at the rising edge of frame sync.
// - hardware reset pin low clears outputs to the selected level.
`timescale 1ns/10ps
`include "dac_cfg.svh"
module dac_reset_ref_gain (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // serial pins
    input  wire logic        sclk,
    input  wire logic        sdin,
    input  wire logic        sync_n,
    // straps and reset pin
    input  wire logic        power_up_level_select,
    input  wire logic        level_select_fitted,
    input  wire logic        reset_pin_n,
    // converter controls
    output logic [7:0][15:0] dac_code,
    output logic [7:0]       power_up_hold,
    output logic             gain_two,
    output logic             ref_disable
);
    frame_if fr ();

    logic [2:0]        pin_s1_ff;
    logic [2:0]        pin_s2_ff;
    logic [1:0]        init_cnt_ff;
    logic [1:0]        nxt_init_cnt;
    logic              ready_ff;
    logic              nxt_ready;
    logic              mid_ff;
    logic              nxt_mid;
    logic [7:0][15:0]  code_ff;
    logic [7:0][15:0]  nxt_code;
    logic [7:0]        hold_ff;
    logic [7:0]        nxt_hold;
    logic              gain_ff;
    logic              nxt_gain;
    logic              ref_ff;
    logic              nxt_ref;
    logic [3:0]        cmd;
    logic [3:0]        addr;
    logic [15:0]       data;
    logic [15:0]       clear_code;
    logic              key_ok;

    serial_frame_rx u_rx (
        .core_clk (core_clk),
        .nrst     (nrst),
        .sclk     (sclk),
        .sdin     (sdin),
        .sync_n   (sync_n),
        .frm      (fr.tx)
    );

    assign cmd        = fr.word[`CMD_HI:`CMD_LO];
    assign addr       = fr.word[`ADDR_HI:`ADDR_LO];
    assign data       = fr.word[`DATA_HI:`DATA_LO];
    assign clear_code = mid_ff ? `MID_CODE : `ZERO_CODE;
    assign key_ok     = addr == `SOFT_RESET_ADDR && data == `SOFT_RESET_KEY;

    // bit 0 reset pin, bit 1 level select, bit 2 select fitted
    always_comb begin
        nxt_init_cnt = init_cnt_ff;
        nxt_ready    = ready_ff;
        nxt_mid      = mid_ff;
        nxt_code     = code_ff;
        nxt_hold     = hold_ff;
        nxt_gain     = gain_ff;
        nxt_ref      = ref_ff;
        if (!ready_ff) begin
            // straps caught once the pin synchronisers have filled
            if (init_cnt_ff == `INIT_CYCLES) begin
                nxt_ready = 1'b1;
                nxt_mid   = pin_s2_ff[2] & pin_s2_ff[1];
                nxt_code  = pin_s2_ff[2] & pin_s2_ff[1] ?
                            {8{`MID_CODE}} : {8{`ZERO_CODE}};
                nxt_hold  = 8'hFF;
            end else begin
                nxt_init_cnt = init_cnt_ff + 2'h1;
            end
        end else if (!pin_s2_ff[0]) begin
            nxt_code = {8{clear_code}};
            nxt_hold = 8'hFF;
        end else if (fr.valid) begin
            case (cmd)
                `CMD_WRITE_UPD: begin
                    if (!addr[3]) begin
                        nxt_code[addr[2:0]] = data;
                        nxt_hold[addr[2:0]] = 1'b0;
                    end
                end
                `CMD_SOFT_RESET: begin
                    if (key_ok) begin
                        nxt_code = {8{clear_code}};
                        nxt_hold = 8'hFF;
                        nxt_gain = `GAIN_RST;
                        nxt_ref  = `REF_OFF_RST;
                    end
                end
                `CMD_REF_GAIN: begin
                    // only bits two and zero are used
                    nxt_gain = fr.word[`GAIN_BIT];
                    nxt_ref  = fr.word[`REF_BIT];
                end
                default: begin
                    nxt_gain = gain_ff;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_ff   <= `PIN_SYNC_RST;
            pin_s2_ff   <= `PIN_SYNC_RST;
            init_cnt_ff <= 2'h0;
            ready_ff    <= 1'b0;
            mid_ff      <= 1'b0;
            code_ff     <= {8{`ZERO_CODE}};
            hold_ff     <= 8'hFF;
            gain_ff     <= `GAIN_RST;
            ref_ff      <= `REF_OFF_RST;
        end else begin
            pin_s1_ff   <= {level_select_fitted, power_up_level_select,
                            reset_pin_n};
            pin_s2_ff   <= pin_s1_ff;
            init_cnt_ff <= nxt_init_cnt;
            ready_ff    <= nxt_ready;
            mid_ff      <= nxt_mid;
            code_ff     <= nxt_code;
            hold_ff     <= nxt_hold;
            gain_ff     <= nxt_gain;
            ref_ff      <= nxt_ref;
        end
    end

    assign dac_code      = code_ff;
    assign power_up_hold = hold_ff;
    assign gain_two      = gain_ff;
    assign ref_disable   = ref_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_up_zero;
        $rose(ready_ff) && !$past(pin_s2_ff[1]) |->
            dac_code == {8{`ZERO_CODE}} && power_up_hold == 8'hFF;
    endproperty
    a_up_zero: assert property (p_up_zero)
        else $error("power-up with select low not at zero-scale");

    property p_up_mid;
        $rose(ready_ff) && $past(pin_s2_ff[1]) && $past(pin_s2_ff[2]) |->
            dac_code == {8{`MID_CODE}};
    endproperty
    a_up_mid: assert property (p_up_mid)
        else $error("power-up with select high not at midscale");

    property p_up_no_pin;
        $rose(ready_ff) && !$past(pin_s2_ff[2]) |->
            dac_code == {8{`ZERO_CODE}};
    endproperty
    a_up_no_pin: assert property (p_up_no_pin)
        else $error("variant without select pin not at zero-scale");

    property p_hold_level;
        ready_ff && !fr.valid && pin_s2_ff[0] |=>
            $stable(dac_code) && $stable(power_up_hold);
    endproperty
    a_hold_level: assert property (p_hold_level)
        else $error("outputs moved without a write");

    sequence s_good_reset;
        ready_ff && pin_s2_ff[0] && fr.valid && cmd == `CMD_SOFT_RESET
            && key_ok;
    endsequence

    property p_soft_reset;
        s_good_reset |=> dac_code == {8{$past(clear_code)}} && !gain_two
            && !ref_disable && power_up_hold == 8'hFF;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not restore power-on state");

    property p_bad_key;
        ready_ff && pin_s2_ff[0] && fr.valid && cmd == `CMD_SOFT_RESET
            && !key_ok |=>
            $stable(dac_code) && $stable(gain_two) && $stable(ref_disable)
            && $stable(power_up_hold);
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("soft reset with wrong key changed state");

    property p_gain;
        ready_ff && pin_s2_ff[0] && fr.valid && cmd == `CMD_REF_GAIN |=>
            gain_two == $past(fr.word[`GAIN_BIT]);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain bit not applied");

    property p_ref;
        ready_ff && pin_s2_ff[0] && fr.valid && cmd == `CMD_REF_GAIN |=>
            ref_disable == $past(fr.word[`REF_BIT]);
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference bit not applied");

    property p_hw_reset;
        ready_ff && !pin_s2_ff[0] |=> dac_code == {8{$past(clear_code)}};
    endproperty
    a_hw_reset: assert property (p_hw_reset)
        else $error("reset pin did not clear outputs");
endmodule

// *** verif/host_spi_model.sv ***
// host serial controller model that shifts command frames
`timescale 1ns/10ps
module host_spi_model (
    // serial pins
    output logic sclk,
    output logic sdin,
    output logic sync_n
);
    initial begin
        sclk   = 1'b1;
        sdin   = 1'b0;
        sync_n = 1'b1;
    end

    // msb first, bits past the 24th are zeros; sclk idles high
    task automatic send(input dac_pkg::frame_word_t w, input int nbits);
        sync_n = 1'b0;
        // keeps pin edges off the sampling clock edge
        #0.25;
        for (int i = 0; i < nbits; i++) begin
            sdin = (i < 24) ? w[23 - i] : 1'b0;
            #62.5 sclk = 1'b0;
            #62.5 sclk = 1'b1;
        end
        #62.5 sync_n = 1'b1;
        sdin = ~sdin;
        #200;
    endtask
endmodule

// *** verif/dac_reset_ref_gain_test.sv ***
// self-checking bench for the reset and reference/gain control
`timescale 1ns/10ps
`include "dac_cfg.svh"
module dac_reset_ref_gain_test;
    logic             core_clk;
    logic             nrst;
    logic             sclk;
    logic             sdin;
    logic             sync_n;
    logic             power_up_level_select;
    logic             level_select_fitted;
    logic             reset_pin_n;
    logic [7:0][15:0] dac_code;
    logic [7:0]       power_up_hold;
    logic             gain_two;
    logic             ref_disable;
    int               failures;
    int               n_tests;
    int               seed;
    logic [31:0]      r;
    logic [15:0]      exp_code [8];
    logic [15:0]      clear_code;
    logic [7:0]       exp_hold;
    logic             exp_gain;
    logic             exp_ref;

    dac_reset_ref_gain dac_reset_ref_gain_i (
        .core_clk              (core_clk),
        .nrst                  (nrst),
        .sclk                  (sclk),
        .sdin                  (sdin),
        .sync_n                (sync_n),
        .power_up_level_select (power_up_level_select),
        .level_select_fitted   (level_select_fitted),
        .reset_pin_n           (reset_pin_n),
        .dac_code              (dac_code),
        .power_up_hold         (power_up_hold),
        .gain_two              (gain_two),
        .ref_disable           (ref_disable)
    );

    host_spi_model host_spi_model_i (
        .sclk   (sclk),
        .sdin   (sdin),
        .sync_n (sync_n)
    );

    always #4 core_clk = ~core_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_all();
        for (int c = 0; c < 8; c++) begin
            chk(dac_code[c], exp_code[c]);
        end
        chk({8'h00, power_up_hold}, {8'h00, exp_hold});
        chk({15'h0000, gain_two}, {15'h0000, exp_gain});
        chk({15'h0000, ref_disable}, {15'h0000, exp_ref});
    endtask

    task automatic model_clear();
        for (int c = 0; c < 8; c++) begin
            exp_code[c] = clear_code;
        end
        exp_hold = 8'hFF;
    endtask

    task automatic do_reset(input logic sel, input logic fit);
        @(negedge core_clk);
        nrst = 1'b0;
        power_up_level_select = sel;
        level_select_fitted = fit;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        clear_code = (sel & fit) ? `MID_CODE : `ZERO_CODE;
        model_clear();
        exp_gain = 1'b0;
        exp_ref = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask

    // sends one frame and applies it to the reference model
    task automatic frame(input logic [23:0] w, input int n);
        @(negedge core_clk);
        host_spi_model_i.send(w, n);
        // frames are ignored while the reset pin is low
        if (n == 24 && reset_pin_n) begin
            case (w[23:20])
                `CMD_WRITE_UPD: if (!w[19]) begin
                    exp_code[w[18:16]] = w[15:0];
                    exp_hold[w[18:16]] = 1'b0;
                end
                `CMD_SOFT_RESET: if (w[19:16] == `SOFT_RESET_ADDR &&
                                     w[15:0] == `SOFT_RESET_KEY) begin
                    model_clear();
                    exp_gain = 1'b0;
                    exp_ref = 1'b0;
                end
                `CMD_REF_GAIN: begin
                    exp_gain = w[`GAIN_BIT];
                    exp_ref = w[`REF_BIT];
                end
                default: ;
            endcase
        end
        repeat (4) @(negedge core_clk);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        power_up_level_select = 1'b0;
        level_select_fitted = 1'b1;
        reset_pin_n = 1'b1;
        failures = 0;
        n_tests = 0;
        seed = 32'hD89A7C7C;
        do_reset(1'b0, 1'b1);
        check_all();
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            frame({`CMD_WRITE_UPD, 1'b0, r[18:0]}, 24);
            check_all();
        end
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            frame({`CMD_REF_GAIN, r[19:3], k[1], 1'b0, k[0]}, 24);
            check_all();
        end
        r = $random(seed);
        frame({`CMD_WRITE_UPD, 1'b1, r[18:0]}, 24);
        frame({4'h0, r[19:0]}, 24);
        frame(24'h611234, 24);
        frame(24'h601235, 24);
        check_all();
        frame(24'h601234, 23);
        frame(24'h601234, 25);
        check_all();
        frame(24'h601234, 24);
        check_all();
        do_reset(1'b1, 1'b1);
        check_all();
        r = $random(seed);
        frame({`CMD_WRITE_UPD, 1'b0, r[18:0]}, 24);
        frame(24'h700004, 24);
        check_all();
        @(negedge core_clk);
        reset_pin_n = 1'b0;
        model_clear();
        repeat (6) @(negedge core_clk);
        check_all();
        r = $random(seed);
        frame({`CMD_WRITE_UPD, 1'b0, r[18:0]}, 24);
        check_all();
        reset_pin_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check_all();
        frame(24'h601234, 24);
        check_all();
        do_reset(1'b1, 1'b0);
        check_all();
        frame(24'h700004, 24);
        check_all();
        complete_run();
    end
endmodule
